// File: dv/rdw_carrier.sv
`timescale 1ns/1ns
`default_nettype none
`include "rdw_cfg.svh"

module rdw_carrier (
    input wire logic hold_reset_i,
    input wire logic press_default_i,
    input wire logic wake_level_i,
    output logic external_reset_n_o,
    output logic default_n_o,
    output logic wake_o
);
    // A released pin is driven to RDW_PIN_IDLE, the high level its pull-up would give it.
    assign external_reset_n_o = hold_reset_i ? 1'b0 :
                                `RDW_PIN_IDLE;
    assign default_n_o = press_default_i ? 1'b0 :
                         `RDW_PIN_IDLE;
    // The carrier drives wake actively in both directions.
    assign wake_o = wake_level_i;
endmodule

`default_nettype wire

// File: dv/reset_default_wake_control_bench.sv
`timescale 1ns/1ns
`default_nettype none

module reset_default_wake_control_bench;
    localparam int unsigned HB = 200;
    localparam int unsigned RB = 20;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic hold_rst = 1'b0;
    logic press = 1'b0;
    logic wake = 1'b0;
    logic wake_en = 1'b1;
    logic [31:0] seed = 32'h56;
    wire logic ext_n;
    wire logic dflt_n;
    wire logic wake_pin;
    logic [1:0] cpu, rest, cli, led, wev, slp;
    int c_cpu[2], c_rest[2], c_wev[2], c_led[2];
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    int exp_w = 0;

    always #10 clk_i = ~clk_i;

    rdw_carrier u_rdw_carrier (
        .hold_reset_i(hold_rst), .press_default_i(press),
        .wake_level_i(wake), .external_reset_n_o(ext_n),
        .default_n_o(dflt_n), .wake_o(wake_pin)
    );

    // Index 0 is the wired variant, index 1 the wireless one.
    for (genvar i = 0; i < 2; i++) begin : g_dut
        rdw_reset_default_wake #(
            .WIRELESS(1'(i)), .FILT_CYCLES(4), .HOLD_CYC(HB),
            .BLINK_START_CYC(150), .BLINK_HALF_CYC(10), .REBOOT_CYC(RB)
        ) u_rdw_reset_default_wake (
            .clk_i(clk_i), .rst_i(rst_i), .external_reset_n_i(ext_n),
            .default_n_i(dflt_n), .wake_i(wake_pin),
            .wake_enable_i(wake_en), .cpu_reset_o(cpu[i]),
            .factory_restore_o(rest[i]), .cli_boot_o(cli[i]),
            .status_indicator_out_o(led[i]), .wake_event_o(wev[i]),
            .sleep_allow_o(slp[i])
        );
    end

    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction

    // Restores expected from a press of len cycles while running.
    // The filter lag is the same on both edges, so only len counts.
    function automatic int exp_restores(input int len);
        return (len > HB) ? 1 : 0;
    endfunction

    task automatic end_sim();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk_bit(input string what, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %b seen %b", what, e, g);
        end
    endtask

    task automatic chk_cnt(input string what, input int e, input int g);
        checks_done++;
        if (g != e) begin
            n_errors++;
            $display("MISMATCH %s expected %0d seen %0d", what, e, g);
        end
    endtask

    task automatic clr();
        for (int i = 0; i < 2; i++) begin
            c_cpu[i] = 0;
            c_rest[i] = 0;
            c_wev[i] = 0;
            c_led[i] = 0;
        end
    endtask

    // Samples outputs just after each edge; callers drive pins right after.
    task automatic step(input int n);
        repeat (n) begin
            @(posedge clk_i);
            #1;
            for (int i = 0; i < 2; i++) begin
                c_cpu[i] += int'(cpu[i] === 1'b1);
                c_rest[i] += int'(rest[i] === 1'b1);
                c_wev[i] += int'(wev[i] === 1'b1);
                c_led[i] += int'(led[i] === 1'b0);
            end
            chk_bit("outs_known", 1'b0,
                    $isunknown({cpu, rest, cli, led, wev, slp}));
        end
    endtask

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            n_errors++;
            end_sim();
        end
    end

    initial begin
        repeat (15) @(posedge clk_i);
        #1;
        chk_bit("cpu_reset_in_rst", 1'b1, cpu[1]);
        step(1);
        rst_i = 1'b0;
        step(20);
        for (int i = 0; i < 2; i++) begin
            chk_bit("cpu_reset_idle", 1'b0, cpu[i]);
            chk_bit("led_lit", 1'b1, led[i]);
            chk_bit("sleep_allow", 1'(i), slp[i]);
        end
        clr();
        hold_rst = 1'b1;
        step(2);
        hold_rst = 1'b0;
        step(20);
        chk_cnt("reset_glitch", 0, c_cpu[0] + c_cpu[1]);
        hold_rst = 1'b1;
        step(30);
        chk_bit("external_reset_n_held", 1'b1, cpu[0]);
        hold_rst = 1'b0;
        step(15);
        chk_bit("external_reset_n_freed", 1'b0, cpu[0]);
        clr();
        wake = 1'b1;
        step(30);
        chk_cnt("wake_wireless", 1, c_wev[1]);
        chk_cnt("wake_wired", 0, c_wev[0]);
        chk_bit("sleep_blocked", 1'b0, slp[1]);
        wake = 1'b0;
        wake_en = 1'b0;
        step(20);
        wake = 1'b1;
        step(20);
        wake = 1'b0;
        step(20);
        chk_cnt("wake_masked", 1, c_wev[1]);
        chk_bit("sleep_again", 1'b1, slp[1]);
        wake_en = 1'b1;
        clr();
        for (int k = 0; k < 3; k++) begin
            seed = xs(seed);
            press = 1'b1;
            step(20 + int'(seed % 32'd100));
            exp_w += exp_restores(20 + int'(seed % 32'd100));
            press = 1'b0;
            step(20);
        end
        // A press of exactly the hold time is one cycle too short.
        press = 1'b1;
        step(HB);
        exp_w += exp_restores(HB);
        press = 1'b0;
        step(20);
        chk_cnt("short_restore", exp_w, c_rest[0] + c_rest[1]);
        chk_cnt("short_reboot", 0, c_cpu[0] + c_cpu[1]);
        clr();
        press = 1'b1;
        step(215);
        chk_cnt("wired_restore", exp_restores(215), c_rest[0]);
        chk_cnt("wireless_waits", 0, c_rest[1]);
        chk_bit("wired_rebooting", 1'b1, cpu[0]);
        press = 1'b0;
        step(50);
        chk_cnt("wireless_restore", exp_restores(215), c_rest[1]);
        for (int i = 0; i < 2; i++) begin
            chk_cnt("reboot_len", RB, c_cpu[i]);
            chk_cnt("led_blinked", 1, int'(c_led[i] > 0));
            chk_bit("led_relit", 1'b1, led[i]);
        end
        clr();
        hold_rst = 1'b1;
        press = 1'b1;
        step(30);
        hold_rst = 1'b0;
        step(40);
        chk_bit("cli_wireless", 1'b1, cli[1]);
        chk_bit("cli_wired", 1'b0, cli[0]);
        chk_cnt("boot_restore_wired", 1, c_rest[0]);
        press = 1'b0;
        step(30);
        chk_cnt("cli_keeps_config", 0, c_rest[1]);
        end_sim();
    end
endmodule

`default_nettype wire

// File: src/rdw_cfg.svh
`ifndef RDW_CFG_SVH
`define RDW_CFG_SVH

`define RDW_CLK_HZ 50000000
`define RDW_CYC_PER_MS (`RDW_CLK_HZ / 1000)

// Least low time of the external reset that the carrier must provide.
`define RDW_EXTERNAL_RESET_N_MIN_MS 50
`define RDW_EXTERNAL_RESET_N_MIN_CYC (`RDW_EXTERNAL_RESET_N_MIN_MS * `RDW_CYC_PER_MS)

`define RDW_HOLD_MS 6000
`define RDW_HOLD_CYC (`RDW_HOLD_MS * `RDW_CYC_PER_MS)

`define RDW_BLINK_START_MS 5000
`define RDW_BLINK_START_CYC (`RDW_BLINK_START_MS * `RDW_CYC_PER_MS)

`define RDW_BLINK_HALF_MS 500
`define RDW_BLINK_HALF_CYC (`RDW_BLINK_HALF_MS * `RDW_CYC_PER_MS)

`define RDW_REBOOT_MS 200
`define RDW_REBOOT_CYC (`RDW_REBOOT_MS * `RDW_CYC_PER_MS)

`define RDW_FILT_CYCLES 16
`define RDW_PIN_IDLE 1'b1

`endif

// File: src/rdw_pin_filter.sv
`timescale 1ns/1ns
`default_nettype none
`include "rdw_cfg.svh"

module rdw_pin_filter #(
    parameter logic INIT = `RDW_PIN_IDLE,
    parameter int unsigned FILT_CYCLES = `RDW_FILT_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pin_i,
    output logic level_o
);

    rdw_pkg::rdw_filt_t q_ff;
    rdw_pkg::rdw_filt_t nxt_q;

    always_comb begin
        nxt_q = q_ff;
        nxt_q.sync1 = pin_i;
        nxt_q.sync2 = q_ff.sync1;
        // The output follows only a level that stayed put for the whole window.
        if (q_ff.sync2 == q_ff.out) begin
            nxt_q.cnt = 16'h0000;
        end else if (q_ff.cnt == 16'(FILT_CYCLES - 1)) begin
            nxt_q.out = q_ff.sync2;
            nxt_q.cnt = 16'h0000;
        end else begin
            nxt_q.cnt = q_ff.cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_ff <= {INIT, INIT, INIT, 16'h0000};
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign level_o = q_ff.out;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_filter_glitch_hold: assert property (
        (q_ff.sync2 != q_ff.out) && (q_ff.cnt != 16'(FILT_CYCLES - 1))
        |=> $stable(level_o))
        else $error("Filtered level moved before the window ran out.");

    chk_filter_takes_level: assert property (
        (q_ff.sync2 != q_ff.out) && (q_ff.cnt == 16'(FILT_CYCLES - 1))
        |=> level_o == $past(q_ff.sync2))
        else $error("Filtered level did not follow a steady input.");

endmodule

`default_nettype wire

// File: src/rdw_pkg.sv
package rdw_pkg;

    typedef enum logic [1:0] {
        rdw_st_run    = 2'b00,
        rdw_st_hold   = 2'b01,
        rdw_st_armed  = 2'b11,
        rdw_st_reboot = 2'b10
    } rdw_state_t;

    typedef struct packed {
        rdw_state_t st;
        logic [31:0] hold_cnt;
        logic [31:0] blink_cnt;
        logic [31:0] reb_cnt;
        logic led;
        logic cli;
        logic block;
        logic restore;
        logic wake_prev;
        logic wake_evt;
        logic rst_prev;
    } rdw_top_t;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic out;
        logic [15:0] cnt;
    } rdw_filt_t;

endpackage

// File: src/rdw_reset_default_wake.sv
// Functional notes
// - Low external reset holds processor in reset.
// - Floating external reset reads high, unit runs.
// - Default low six seconds restores, reboots.
// - Wired: default low at boot restores defaults.
// - Wireless: held over 6 s, release restores.
// - Wireless: default low at boot starts CLI.
// - Wireless: wake rising edge brings unit out of sleep.
// - Wake low allows sleep, subject to configuration.
// - Indicator lit; blinks after 5 s hold.
`timescale 1ns/1ns
`default_nettype none
`include "rdw_cfg.svh"

module rdw_reset_default_wake #(
    parameter logic WIRELESS = 1'b1,
    parameter int unsigned FILT_CYCLES = `RDW_FILT_CYCLES,
    parameter int unsigned HOLD_CYC = `RDW_HOLD_CYC,
    parameter int unsigned BLINK_START_CYC = `RDW_BLINK_START_CYC,
    parameter int unsigned BLINK_HALF_CYC = `RDW_BLINK_HALF_CYC,
    parameter int unsigned REBOOT_CYC = `RDW_REBOOT_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic external_reset_n_i,
    input wire logic default_n_i,
    input wire logic wake_i,
    input wire logic wake_enable_i,
    output logic cpu_reset_o,
    output logic factory_restore_o,
    output logic cli_boot_o,
    output logic status_indicator_out_o,
    output logic wake_event_o,
    output logic sleep_allow_o
);

    logic ext_rst_n_f;
    logic default_n_f;
    logic wake_f;
    logic boot_edge;
    rdw_pkg::rdw_top_t q_ff;
    rdw_pkg::rdw_top_t nxt_q;

    // The pins idle high through their pull-ups, so each filter starts high.
    rdw_pin_filter #(
        .INIT(`RDW_PIN_IDLE),
        .FILT_CYCLES(FILT_CYCLES)
    ) u_reset_filt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(external_reset_n_i),
        .level_o(ext_rst_n_f)
    );

    rdw_pin_filter #(
        .INIT(`RDW_PIN_IDLE),
        .FILT_CYCLES(FILT_CYCLES)
    ) u_default_filt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(default_n_i),
        .level_o(default_n_f)
    );

    rdw_pin_filter #(
        .INIT(`RDW_PIN_IDLE),
        .FILT_CYCLES(FILT_CYCLES)
    ) u_wake_filt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(wake_i),
        .level_o(wake_f)
    );

    // A high or undriven pin leaves the processor running.
    assign cpu_reset_o = rst_i || !ext_rst_n_f ||
                         (q_ff.st == rdw_pkg::rdw_st_reboot);
    assign boot_edge = q_ff.rst_prev && !cpu_reset_o;

    always_comb begin
        nxt_q = q_ff;
        nxt_q.restore = 1'b0;
        nxt_q.wake_evt = 1'b0;
        nxt_q.rst_prev = cpu_reset_o;
        nxt_q.wake_prev = wake_f;
        nxt_q.led = 1'b1;
        if (WIRELESS && wake_enable_i && wake_f && !q_ff.wake_prev) begin
            nxt_q.wake_evt = 1'b1;
        end
        if (default_n_f) begin
            nxt_q.block = 1'b0;
        end
        if (!ext_rst_n_f) begin
            // A hardware reset abandons any hold sequence in progress.
            nxt_q.st = rdw_pkg::rdw_st_run;
            nxt_q.hold_cnt = 32'h0000_0000;
            nxt_q.cli = 1'b0;
        end else if (boot_edge) begin
            nxt_q.st = rdw_pkg::rdw_st_run;
            nxt_q.hold_cnt = 32'h0000_0000;
            nxt_q.cli = 1'b0;
            if (!default_n_f) begin
                // A pin held through boot is not timed until it is let go.
                nxt_q.block = 1'b1;
                if (WIRELESS) begin
                    nxt_q.cli = 1'b1;
                end else begin
                    nxt_q.restore = 1'b1;
                end
            end
        end else begin
            unique case (q_ff.st)
                rdw_pkg::rdw_st_run: begin
                    nxt_q.hold_cnt = 32'h0000_0000;
                    nxt_q.blink_cnt = 32'h0000_0000;
                    if (!default_n_f && !q_ff.block) begin
                        nxt_q.st = rdw_pkg::rdw_st_hold;
                    end
                end
                rdw_pkg::rdw_st_hold: begin
                    nxt_q.hold_cnt = q_ff.hold_cnt + 32'h0000_0001;
                    nxt_q.led = q_ff.led;
                    if (q_ff.hold_cnt < 32'(BLINK_START_CYC)) begin
                        nxt_q.led = 1'b1;
                    end else if (q_ff.blink_cnt ==
                                 32'(BLINK_HALF_CYC - 1)) begin
                        nxt_q.led = !q_ff.led;
                        nxt_q.blink_cnt = 32'h0000_0000;
                    end else begin
                        nxt_q.blink_cnt = q_ff.blink_cnt + 32'h0000_0001;
                    end
                    if (default_n_f) begin
                        nxt_q.st = rdw_pkg::rdw_st_run;
                        nxt_q.led = 1'b1;
                    end else if (q_ff.hold_cnt == 32'(HOLD_CYC - 1)) begin
                        if (WIRELESS) begin
                            nxt_q.st = rdw_pkg::rdw_st_armed;
                        end else begin
                            nxt_q.st = rdw_pkg::rdw_st_reboot;
                            nxt_q.restore = 1'b1;
                            nxt_q.reb_cnt = 32'h0000_0000;
                        end
                    end
                end
                rdw_pkg::rdw_st_armed: begin
                    nxt_q.led = q_ff.led;
                    if (q_ff.blink_cnt == 32'(BLINK_HALF_CYC - 1)) begin
                        nxt_q.led = !q_ff.led;
                        nxt_q.blink_cnt = 32'h0000_0000;
                    end else begin
                        nxt_q.blink_cnt = q_ff.blink_cnt + 32'h0000_0001;
                    end
                    if (default_n_f) begin
                        nxt_q.st = rdw_pkg::rdw_st_reboot;
                        nxt_q.restore = 1'b1;
                        nxt_q.reb_cnt = 32'h0000_0000;
                        nxt_q.led = 1'b1;
                    end
                end
                rdw_pkg::rdw_st_reboot: begin
                    nxt_q.reb_cnt = q_ff.reb_cnt + 32'h0000_0001;
                    if (q_ff.reb_cnt == 32'(REBOOT_CYC - 1)) begin
                        nxt_q.st = rdw_pkg::rdw_st_run;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_ff <= '0;
            q_ff.led <= 1'b1;
            q_ff.wake_prev <= `RDW_PIN_IDLE;
            q_ff.rst_prev <= 1'b1;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign factory_restore_o = q_ff.restore;
    assign cli_boot_o = q_ff.cli;
    assign status_indicator_out_o = q_ff.led;
    assign wake_event_o = q_ff.wake_evt;
    assign sleep_allow_o = WIRELESS && !wake_f;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_boot_default_low;
        boot_edge && ext_rst_n_f && !default_n_f;
    endsequence

    sequence s_armed_release;
        (q_ff.st == rdw_pkg::rdw_st_armed) ##1
        ((q_ff.st == rdw_pkg::rdw_st_armed) && default_n_f && ext_rst_n_f);
    endsequence

    chk_external_reset_n_hold: assert property (
        !ext_rst_n_f |-> cpu_reset_o ##1 (q_ff.st == rdw_pkg::rdw_st_run))
        else $error("Processor not held in reset while the pin is low.");

    chk_reset_idle_runs: assert property (
        ext_rst_n_f && (q_ff.st != rdw_pkg::rdw_st_reboot) |-> !cpu_reset_o)
        else $error("Processor held in reset with the pin high.");

    chk_wired_hold_restore: assert property (
        !WIRELESS && ext_rst_n_f && !default_n_f &&
        (q_ff.st == rdw_pkg::rdw_st_hold) &&
        (q_ff.hold_cnt == 32'(HOLD_CYC - 1))
        |=> factory_restore_o && cpu_reset_o)
        else $error("Six second hold did not restore and reboot.");

    chk_restore_reboots: assert property (
        factory_restore_o && (q_ff.st == rdw_pkg::rdw_st_reboot)
        |-> cpu_reset_o [*2])
        else $error("Restore was not followed by a reboot.");

    chk_wired_boot_default: assert property (
        (!WIRELESS) and s_boot_default_low
        |=> factory_restore_o && !cli_boot_o)
        else $error("Wired boot with default low did not restore.");

    chk_release_restore: assert property (
        s_armed_release |=> factory_restore_o && cpu_reset_o)
        else $error("Release after long hold did not restore.");

    chk_boot_cli_session: assert property (
        (WIRELESS) and s_boot_default_low
        |=> cli_boot_o && !factory_restore_o ##1 !factory_restore_o)
        else $error("Boot with default low did not start the session.");

    chk_wake_edge_event: assert property (
        WIRELESS && wake_enable_i && $rose(wake_f) |=> wake_event_o)
        else $error("Wake rising edge gave no wake event.");

    chk_wake_high_sleep: assert property (
        wake_f |-> !sleep_allow_o)
        else $error("Sleep allowed while wake is high.");

    chk_led_steady_on: assert property (
        (q_ff.st == rdw_pkg::rdw_st_run) &&
        $past(q_ff.st == rdw_pkg::rdw_st_run)
        |-> status_indicator_out_o)
        else $error("Indicator dark in normal running.");

    chk_led_no_early_blink: assert property (
        (q_ff.st == rdw_pkg::rdw_st_hold) &&
        (q_ff.hold_cnt < 32'(BLINK_START_CYC)) |-> status_indicator_out_o)
        else $error("Indicator blinked before the blink threshold.");

endmodule

`default_nettype wire
